// [pkg/ledctl_pkg.sv]
// Constants shared by the LED driver control register bank
`default_nettype none

package ledctl_pkg;

    // ------------------------------------------------------------
    // Clock and channel count
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 125_000_000;
    localparam int NCH           = 18;
    localparam int CH_PER_BYTE   = 6;
    localparam int GRP_BYTES     = 3;
    localparam int BLK_BYTES     = 5;
    localparam int CUR_W         = 14;
    localparam int REG_COUNT     = 64;

    // ------------------------------------------------------------
    // Register offsets (write addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] A_CFG    = 6'h00;
    localparam logic [5:0] A_GLOB   = 6'h01;
    localparam logic [5:0] A_SCL    = 6'h02;
    localparam logic [5:0] A_ODET   = 6'h14;
    localparam logic [5:0] A_OPEN   = 6'h15;
    localparam logic [5:0] A_TEMP   = 6'h18;
    localparam logic [5:0] A_SS     = 6'h19;
    localparam logic [5:0] A_DC     = 6'h1a;
    localparam logic [5:0] A_PH     = 6'h1d;
    localparam logic [5:0] A_PH2    = 6'h1e;
    localparam logic [5:0] A_PWM    = 6'h1f;
    localparam logic [5:0] A_BLEN   = 6'h31;
    localparam logic [5:0] A_BRATE  = 6'h34;
    localparam logic [5:0] A_BDUTY  = 6'h35;
    localparam logic [5:0] A_SC_UPD = 6'h36;
    localparam logic [5:0] A_UPD    = 6'h37;
    localparam logic [5:0] A_RST    = 6'h3f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RD_BIT   = 7;
    localparam int MAP_BIT  = 6;
    localparam int BIT_SHDN = 0;
    localparam int BIT_SYNC = 1;
    localparam int BIT_RATE = 4;
    localparam int BIT_MULT = 5;
    localparam int BIT_THR  = 6;
    localparam int BIT_DET  = 0;
    localparam int BIT_REP  = 1;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [1:0] SYNC_MASTER = 2'h2;
    localparam logic [1:0] SYNC_SLAVE  = 2'h3;
    localparam logic [5:0] GLOB_CAP    = 6'h20;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_GLOB = 8'h3f;
    localparam logic [7:0] RST_SCL  = 8'hff;
    localparam logic [7:0] RST_ODET = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] M_CFG    = 8'h77;
    localparam logic [7:0] M_GLOB   = 8'h3f;
    localparam logic [7:0] M_ODET   = 8'h03;
    localparam logic [7:0] M_GRP    = 8'h77;
    localparam logic [7:0] M_TEMP   = 8'hcf;
    localparam logic [7:0] M_SS     = 8'h1f;
    localparam logic [7:0] M_PH     = 8'h71;
    localparam logic [7:0] M_FULL   = 8'hff;
    localparam logic [7:0] M_NONE   = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PWM_STEPS     = 256;
    localparam int PWM_HZ_FAST   = 25_000;
    localparam int PWM_HZ_SLOW   = 200;
    localparam int PWM_DIV_FAST  = CLK_HZ / (PWM_STEPS * PWM_HZ_FAST);
    localparam int PWM_DIV_SLOW  = CLK_HZ / (PWM_STEPS * PWM_HZ_SLOW);
    localparam int BLINK_HZ      = 24;
    localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);

endpackage : ledctl_pkg

`default_nettype wire

// [rtl/ledctl_regbank.sv]
// Register bank, serial link slave and channel control of the 18-channel LED driver
`timescale 1ns/100ps
`default_nettype none

module ledctl_regbank #(
    parameter int NCH               = ledctl_pkg::NCH,
    parameter int BLINK_HALF_CYCLES = ledctl_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic                                clk_sys,
    input  wire logic                                reset,
    input  wire logic                                sck,
    input  wire logic                                cs_n,
    input  wire logic                                mosi,
    output logic                                     miso,
    output logic                                     miso_oe,
    input  wire logic [NCH-1:0]                      open_led_sense,
    input  wire logic                                sync_clock_pin_in,
    output logic                                     sync_clock_pin_out,
    output logic                                     sync_clock_pin_oe,
    output logic                                     interrupt_out_n,
    output logic                                     device_active,
    output logic                                     pwm_rate_select,
    output logic                                     current_multiplier_bit,
    output logic                                     logic_threshold_select,
    output logic [5:0]                               global_current_factor,
    output logic [NCH-1:0]                           led_current_outputs,
    output logic [NCH-1:0][ledctl_pkg::CUR_W-1:0]    channel_current_code,
    output logic [NCH-1:0]                           blink_enable_active,
    output logic [7:0]                               blink_rate_active,
    output logic [7:0]                               blink_on_ratio_active
);

    localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ledctl_pkg::REG_COUNT-1:0][7:0]  regs;
        logic [NCH-1:0][7:0]                    scl_act;
        logic [NCH-1:0][7:0]                    pwm_act;
        logic [ledctl_pkg::BLK_BYTES-1:0][7:0]  blk_act;
        logic [NCH-1:0]                         sc_pend;
        logic [NCH-1:0]                         sc_armed;
        logic [NCH-1:0]                         pwm_on;
        logic [NCH-1:0][ledctl_pkg::CUR_W-1:0]  cur;
        logic [11:0]                            pwm_prs;
        logic [7:0]                             pwm_cnt;
        logic [BW-1:0]                          blk_prs;
        logic [7:0]                             blk_cnt;
        logic                                   sync_out;
        logic                                   sync_oe;
        logic [NCH-1:0]                         opn_s1;
        logic [NCH-1:0]                         opn_s2;
        logic [NCH-1:0]                         opn_s3;
        logic [NCH-1:0]                         opn_f;
        logic [2:0]                             sy_s;
        logic                                   sy_f;
        logic [2:0]                             wr_s;
        logic                                   wr_seen;
        logic [2:0]                             rq_s;
        logic                                   rq_seen;
        logic [7:0]                             rd_word;
        logic                                   int_n;
    } ledctl_sys_s;

    typedef struct packed {
        logic [2:0] bitcnt;
        logic [6:0] sh;
        logic       hdr;
        logic       rd;
        logic [6:0] ptr;
    } ledctl_frm_s;

    typedef struct packed {
        logic       wr_tog;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic       rq_tog;
        logic [6:0] rq_addr;
    } ledctl_ev_s;

    typedef struct packed {
        logic [7:0] tx;
        logic       miso;
        logic       oe;
    } ledctl_tx_s;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] wmask(input logic [5:0] a);
        if (a == ledctl_pkg::A_CFG) return ledctl_pkg::M_CFG;
        else if (a == ledctl_pkg::A_GLOB) return ledctl_pkg::M_GLOB;
        else if (a >= ledctl_pkg::A_SCL && a < ledctl_pkg::A_ODET) return ledctl_pkg::M_FULL;
        else if (a == ledctl_pkg::A_ODET) return ledctl_pkg::M_ODET;
        else if (a == ledctl_pkg::A_TEMP) return ledctl_pkg::M_TEMP;
        else if (a == ledctl_pkg::A_SS) return ledctl_pkg::M_SS;
        else if (a >= ledctl_pkg::A_DC && a < ledctl_pkg::A_PH) return ledctl_pkg::M_GRP;
        else if (a == ledctl_pkg::A_PH) return ledctl_pkg::M_PH;
        else if (a == ledctl_pkg::A_PH2) return ledctl_pkg::M_GRP;
        else if (a >= ledctl_pkg::A_PWM && a < ledctl_pkg::A_BLEN) return ledctl_pkg::M_FULL;
        else if (a >= ledctl_pkg::A_BLEN && a < ledctl_pkg::A_BRATE) return ledctl_pkg::M_GRP;
        else if (a >= ledctl_pkg::A_BRATE && a <= ledctl_pkg::A_UPD) return ledctl_pkg::M_FULL;
        else if (a == ledctl_pkg::A_RST) return ledctl_pkg::M_FULL;
        else return ledctl_pkg::M_NONE;
    endfunction : wmask

    function automatic logic [7:0] rst_val(input logic [5:0] a);
        if (a == ledctl_pkg::A_GLOB) return ledctl_pkg::RST_GLOB;
        else if (a >= ledctl_pkg::A_SCL && a < ledctl_pkg::A_ODET) return ledctl_pkg::RST_SCL;
        else if (a == ledctl_pkg::A_ODET) return ledctl_pkg::RST_ODET;
        else return ledctl_pkg::RST_ZERO;
    endfunction : rst_val

    function automatic logic [NCH-1:0] grp_unpack(input logic [ledctl_pkg::GRP_BYTES-1:0][7:0] b);
        logic [NCH-1:0] v;
        v = '0;
        for (int g = 0; g < ledctl_pkg::GRP_BYTES; g++) begin
            v[g*ledctl_pkg::CH_PER_BYTE +: 3]     = b[g][2:0];
            v[g*ledctl_pkg::CH_PER_BYTE + 3 +: 3] = b[g][6:4];
        end
        return v;
    endfunction : grp_unpack

    function automatic logic [7:0] grp_pack(input logic [NCH-1:0] v, input int g);
        return {1'b0, v[g*ledctl_pkg::CH_PER_BYTE + 3 +: 3], 1'b0, v[g*ledctl_pkg::CH_PER_BYTE +: 3]};
    endfunction : grp_pack

    function automatic logic [5:0] glob_eff(input logic [5:0] raw);
        return (raw >= ledctl_pkg::GLOB_CAP) ? ledctl_pkg::GLOB_CAP : raw;
    endfunction : glob_eff

    function automatic ledctl_sys_s sys_init();
        ledctl_sys_s s;
        s = '0;
        for (int a = 0; a < ledctl_pkg::REG_COUNT; a++) begin
            s.regs[a] = rst_val(6'(a));
        end
        for (int i = 0; i < NCH; i++) begin
            s.scl_act[i] = ledctl_pkg::RST_SCL;
        end
        s.int_n = 1'b1;
        return s;
    endfunction : sys_init

    localparam ledctl_sys_s SYS_RST = sys_init();

    // ------------------------------------------------------------
    // Link side: frame, events and read shifter on sck
    // ------------------------------------------------------------
    ledctl_frm_s f_q, f_d;
    ledctl_ev_s  e_q, e_d;
    ledctl_tx_s  t_q, t_d;
    ledctl_sys_s q, d;
    wire logic   frame_rst;
    logic [7:0]  byte_in;

    // Frame state ends with the frame itself; sck is idle outside it
    assign frame_rst = reset | cs_n;

    always_comb begin
        f_d         = f_q;
        e_d         = e_q;
        byte_in     = {f_q.sh, mosi};
        f_d.bitcnt  = f_q.bitcnt + 3'h1;
        f_d.sh      = {f_q.sh[5:0], mosi};
        if (f_q.bitcnt == ledctl_pkg::LAST_BIT) begin
            if (!f_q.hdr) begin
                f_d.hdr   = 1'b1;
                f_d.rd    = byte_in[ledctl_pkg::RD_BIT];
                f_d.ptr   = byte_in[6:0];
                if (byte_in[ledctl_pkg::RD_BIT]) begin
                    e_d.rq_tog  = ~e_q.rq_tog;
                    e_d.rq_addr = byte_in[6:0];
                end
            end else if (f_q.rd) begin
                f_d.ptr     = f_q.ptr + 7'h01;
                e_d.rq_tog  = ~e_q.rq_tog;
                e_d.rq_addr = f_q.ptr + 7'h01;
            end else begin
                e_d.wr_tog  = ~e_q.wr_tog;
                e_d.wr_addr = f_q.ptr;
                e_d.wr_data = byte_in;
                f_d.ptr     = f_q.ptr + 7'h01;
            end
        end
    end

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // Toggles and held words outlive the frame
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    // Read word is taken from the system side; host pause keeps it stable
    always_comb begin
        t_d    = t_q;
        t_d.oe = f_q.hdr & f_q.rd;
        if (f_q.hdr && f_q.rd && f_q.bitcnt == 3'h0) begin
            t_d.tx   = {q.rd_word[6:0], 1'b0};
            t_d.miso = q.rd_word[7];
        end else begin
            t_d.tx   = {t_q.tx[6:0], 1'b0};
            t_d.miso = t_q.tx[7];
        end
    end

    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    // ------------------------------------------------------------
    // System side
    // ------------------------------------------------------------
    logic           wr_ev;
    logic           rq_ev;
    logic [5:0]     wa;
    logic [NCH-1:0] flags;
    logic [NCH-1:0] dc;
    logic [11:0]    div;
    logic           wrap;
    logic           sy_rise;
    logic [1:0]     mode;
    logic           run;

    always_comb begin
        d = q;
        // Three-stage syncs; only the agreeing last two stages count
        d.opn_s1 = open_led_sense;
        d.opn_s2 = q.opn_s1;
        d.opn_s3 = q.opn_s2;
        for (int i = 0; i < NCH; i++) begin
            if (q.opn_s2[i] == q.opn_s3[i]) begin
                d.opn_f[i] = q.opn_s3[i];
            end
        end
        d.sy_s = {q.sy_s[1:0], sync_clock_pin_in};
        if (q.sy_s[1] == q.sy_s[2]) begin
            d.sy_f = q.sy_s[2];
        end
        sy_rise = d.sy_f & ~q.sy_f;
        d.wr_s  = {q.wr_s[1:0], e_q.wr_tog};
        d.rq_s  = {q.rq_s[1:0], e_q.rq_tog};
        wr_ev   = (q.wr_s[1] == q.wr_s[2]) && (q.wr_s[2] != q.wr_seen);
        rq_ev   = (q.rq_s[1] == q.rq_s[2]) && (q.rq_s[2] != q.rq_seen);
        if (wr_ev) begin
            d.wr_seen = q.wr_s[2];
        end
        if (rq_ev) begin
            d.rq_seen = q.rq_s[2];
        end
        wa = e_q.wr_addr[5:0];

        // Register writes
        if (wr_ev && !e_q.wr_addr[ledctl_pkg::MAP_BIT]) begin
            if (wa == ledctl_pkg::A_RST) begin
                d.regs     = SYS_RST.regs;
                d.scl_act  = SYS_RST.scl_act;
                d.pwm_act  = SYS_RST.pwm_act;
                d.blk_act  = SYS_RST.blk_act;
                d.sc_pend  = '0;
                d.sc_armed = '0;
            end else begin
                d.regs[wa] = (e_q.wr_data & wmask(wa)) | (q.regs[wa] & ~wmask(wa));
            end
            if (wa == ledctl_pkg::A_SC_UPD) begin
                for (int i = 0; i < NCH; i++) begin
                    if (grp_unpack(q.regs[ledctl_pkg::A_DC +: ledctl_pkg::GRP_BYTES])[i]) begin
                        d.scl_act[i] = q.regs[ledctl_pkg::A_SCL + i];
                    end else begin
                        d.sc_pend[i]  = 1'b1;
                        d.sc_armed[i] = 1'b0;
                    end
                end
            end
            if (wa == ledctl_pkg::A_UPD) begin
                for (int i = 0; i < NCH; i++) begin
                    d.pwm_act[i] = q.regs[ledctl_pkg::A_PWM + i];
                end
                d.blk_act = q.regs[ledctl_pkg::A_BLEN +: ledctl_pkg::BLK_BYTES];
            end
        end

        // Open detection: read clears first, new detection wins
        flags = grp_unpack(d.regs[ledctl_pkg::A_OPEN +: ledctl_pkg::GRP_BYTES]);
        if (rq_ev && !e_q.rq_addr[ledctl_pkg::MAP_BIT]) begin
            d.rd_word = q.regs[e_q.rq_addr[5:0]];
            for (int g = 0; g < ledctl_pkg::GRP_BYTES; g++) begin
                if (e_q.rq_addr[5:0] == ledctl_pkg::A_OPEN + 6'(g)) begin
                    flags[g*ledctl_pkg::CH_PER_BYTE +: ledctl_pkg::CH_PER_BYTE] = '0;
                end
            end
        end else if (rq_ev) begin
            d.rd_word = ledctl_pkg::RST_ZERO;
        end
        if (q.regs[ledctl_pkg::A_ODET][ledctl_pkg::BIT_DET]) begin
            flags = flags | q.opn_f;
        end
        for (int g = 0; g < ledctl_pkg::GRP_BYTES; g++) begin
            d.regs[ledctl_pkg::A_OPEN + g] = grp_pack(flags, g);
        end
        d.int_n = ~(d.regs[ledctl_pkg::A_ODET][ledctl_pkg::BIT_REP] & (|flags));

        // PWM timebase
        run  = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_SHDN];
        dc   = grp_unpack(q.regs[ledctl_pkg::A_DC +: ledctl_pkg::GRP_BYTES]);
        div  = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_RATE] ? 12'(ledctl_pkg::PWM_DIV_SLOW)
                                                               : 12'(ledctl_pkg::PWM_DIV_FAST);
        wrap = 1'b0;
        if (q.pwm_prs >= div - 12'h001) begin
            d.pwm_prs = '0;
            d.pwm_cnt = q.pwm_cnt + 8'h01;
            wrap      = (q.pwm_cnt == 8'hff);
        end else begin
            d.pwm_prs = q.pwm_prs + 12'h001;
        end

        // Channel gates and current codes
        for (int i = 0; i < NCH; i++) begin
            d.pwm_on[i] = run & (dc[i] | (q.pwm_cnt < q.pwm_act[i]));
            if (wrap && q.sc_pend[i]) begin
                d.sc_armed[i] = 1'b1;
            end
            if (q.pwm_on[i] && !d.pwm_on[i] && q.sc_pend[i] && q.sc_armed[i]) begin
                d.scl_act[i]  = q.regs[ledctl_pkg::A_SCL + i];
                d.sc_pend[i]  = 1'b0;
                d.sc_armed[i] = 1'b0;
            end
            d.cur[i] = run ? 14'(glob_eff(q.regs[ledctl_pkg::A_GLOB][5:0])) * 14'(q.scl_act[i])
                           : 14'h0000;
        end

        // Blink timebase and sync pin
        mode = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_SYNC +: 2];
        if (mode == ledctl_pkg::SYNC_SLAVE && sy_rise) begin
            d.blk_prs = '0;
            d.blk_cnt = '0;
        end else if (q.blk_prs >= BW'(BLINK_HALF_CYCLES - 1)) begin
            d.blk_prs = '0;
            if (q.blk_cnt >= q.blk_act[3]) begin
                d.blk_cnt  = '0;
                d.sync_out = ~q.sync_out;
            end else begin
                d.blk_cnt = q.blk_cnt + 8'h01;
            end
        end else begin
            d.blk_prs = q.blk_prs + BW'(1);
        end
        case (mode)
            ledctl_pkg::SYNC_MASTER: begin
                d.sync_oe = 1'b1;
            end
            ledctl_pkg::SYNC_SLAVE: begin
                d.sync_oe  = 1'b0;
                d.sync_out = d.sy_f;
            end
            default: begin
                d.sync_oe  = 1'b0;
                d.sync_out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q <= SYS_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign miso                   = t_q.miso;
    assign miso_oe                = t_q.oe;
    assign sync_clock_pin_out     = q.sync_out & q.sync_oe;
    assign sync_clock_pin_oe      = q.sync_oe;
    assign interrupt_out_n        = q.int_n;
    assign device_active          = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_SHDN];
    assign pwm_rate_select        = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_RATE];
    assign current_multiplier_bit = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_MULT];
    assign logic_threshold_select = q.regs[ledctl_pkg::A_CFG][ledctl_pkg::BIT_THR];
    assign global_current_factor  = q.regs[ledctl_pkg::A_GLOB][5:0];
    assign led_current_outputs    = q.pwm_on;
    assign channel_current_code   = q.cur;
    assign blink_enable_active    = grp_unpack(q.blk_act[2:0]);
    assign blink_rate_active      = q.blk_act[3];
    assign blink_on_ratio_active  = q.blk_act[4];

endmodule : ledctl_regbank

`default_nettype wire

// [verification/ledctl_regbank_props.sv]
// Port-level checks for the LED driver register bank
`timescale 1ns/100ps
`default_nettype none
module ledctl_regbank_props #(
    parameter int NCH = 18
) (
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic             cs_n,
    input wire logic             miso,
    input wire logic             miso_oe,
    input wire logic             sync_clock_pin_out,
    input wire logic             sync_clock_pin_oe,
    input wire logic             device_active,
    input wire logic [5:0]       global_current_factor,
    input wire logic [NCH-1:0]   led_current_outputs,
    input wire logic [NCH-1:0][ledctl_pkg::CUR_W-1:0] channel_current_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Slack of two cycles: gate and code flops may lag the shutdown flag
    sequence s_shut;
        !device_active [*3];
    endsequence
    // High phase of the sync square wave at the shortest blink setting
    sequence s_high;
        (sync_clock_pin_out || !sync_clock_pin_oe) [*7];
    endsequence
    AST_SYNC_REL: assert property (!sync_clock_pin_oe |-> !sync_clock_pin_out) else $error("sync pin high");
    AST_SHUT_GATE: assert property (s_shut |-> led_current_outputs == '0) else $error("gate on in shutdown");
    AST_SHUT_CODE: assert property (s_shut |-> channel_current_code == '0) else $error("current in shutdown");
    AST_CAP: assert property (channel_current_code[0] <= 14'h1fe0) else $error("current above cap");
    AST_MISO_IDLE: assert property (!miso_oe |-> !miso) else $error("miso high while idle");
    AST_CS_DROP: assert property ($rose(cs_n) |-> !miso_oe) else $error("miso kept after frame");
    AST_SYNC_HALF: assert property ($rose(sync_clock_pin_out) |=> s_high) else $error("sync half short");
    AST_FRAME_ONLY: assert property ($changed(global_current_factor) |-> !cs_n) else $error("factor set idle");
endmodule : ledctl_regbank_props
bind ledctl_regbank ledctl_regbank_props #(.NCH(NCH)) i_ledctl_regbank_props (.clk_sys, .reset, .cs_n, .miso,
    .miso_oe, .sync_clock_pin_out, .sync_clock_pin_oe, .device_active, .global_current_factor,
    .led_current_outputs, .channel_current_code);
`default_nettype wire

// [verification/ledctl_host_model.sv]
// Host serial link master model
`timescale 1ns/100ps
`default_nettype none
module ledctl_host_model (
    output logic        sck,
    output logic        cs_n,
    output logic        mosi,
    output logic [31:0] rx,
    input  wire logic   miso,
    input  wire logic   miso_oe
);
    initial {sck, cs_n, mosi, rx} = {2'b01, 1'b0, 32'h0};
    // Link clock runs only inside a frame, 6 ns period except for the last bit of each byte
    task automatic frame(input logic [31:0] tx, input int n);
        cs_n = 1'b0;
        #10;
        for (int k = 0; k < n; k++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = tx[24 - 8 * k + b];
                #3 sck = 1'b1;
                rx[24 - 8 * k + b] = miso_oe & miso;
                #(b == 0 ? 64 : 3) sck = 1'b0; // Gap lets read data cross domains
            end
        end
        #10 cs_n = 1'b1;
        mosi = ~mosi;
        #20;
    endtask : frame
endmodule : ledctl_host_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the LED driver register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic              clk_sys, reset, ext_sync, sck, cs_n, mosi, miso, miso_oe, s_out, s_oe, int_n, act, rate, mult, thr;
    logic              sync_pin;
    logic [17:0]       sense, gate;
    logic [5:0]        gfac;
    logic [17:0][13:0] code;
    logic [7:0]        ratio;
    logic [31:0]       rx;
    int                fails, checks_done;
    localparam logic [7:0] RA [6] = '{8'h80, 8'h81, 8'h82, 8'h94, 8'h95, 8'hc0};
    localparam logic [7:0] RV [6] = '{8'h00, 8'h3f, 8'hff, 8'h03, 8'h00, 8'h00};
    assign sync_pin = s_oe ? s_out : ext_sync;
    always #4 clk_sys = ~clk_sys;
    ledctl_regbank #(.BLINK_HALF_CYCLES(8)) i_ledctl_regbank (.clk_sys, .reset, .sck, .cs_n, .mosi, .miso,
        .miso_oe, .open_led_sense(sense), .sync_clock_pin_in(sync_pin), .sync_clock_pin_out(s_out),
        .sync_clock_pin_oe(s_oe), .interrupt_out_n(int_n), .device_active(act), .pwm_rate_select(rate),
        .current_multiplier_bit(mult), .logic_threshold_select(thr), .global_current_factor(gfac),
        .led_current_outputs(gate), .channel_current_code(code), .blink_enable_active(), .blink_rate_active(),
        .blink_on_ratio_active(ratio));
    ledctl_host_model i_ledctl_host_model (.sck, .cs_n, .mosi, .rx, .miso, .miso_oe);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ledctl_host_model.frame({a, d, 16'h0}, 2);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_ledctl_host_model.frame({a, 24'h0}, 2);
        chk(16'(rx[23:16]), 16'(e));
    endtask : rd
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        {clk_sys, reset, ext_sync, sense, fails, checks_done} = {2'b01, 1'b0, 18'h0, 32'h0, 32'h0};
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 6; i++) rd(RA[i], RV[i]);
        wr(8'h00, 8'hff);
        rd(8'h80, 8'h77);
        chk(16'({act, rate, mult, thr, s_oe}), 16'h1e);
        wr(8'h00, 8'h05);
        chk(16'(s_oe), 16'h1);
        repeat (60) @(posedge clk_sys);
        wr(8'h00, 8'h01);
        chk(16'({s_oe, s_out}), 16'h0);
        wr(8'h1a, 8'h01);
        i_ledctl_host_model.frame({8'h01, 8'h2f, 8'h80, 8'h00}, 3);
        chk(16'(code[0]), 16'h1fe0);
        wr(8'h36, 8'h01);
        chk(16'(code[0]), 16'h1000);
        chk(16'(gate[0]), 16'h1);
        i_ledctl_host_model.frame({8'h81, 24'h0}, 3);
        chk(16'(rx[23:16]), 16'h2f);
        chk(16'(rx[15:8]), 16'h80);
        wr(8'h01, 8'h05);
        chk(16'(code[0]), 16'h0280);
        chk(16'(gfac), 16'h05);
        wr(8'h35, 8'h5a);
        chk(16'(ratio), 16'h0);
        wr(8'h37, 8'h01);
        chk(16'(ratio), 16'h5a);
        @(posedge clk_sys) sense <= 18'h8;
        repeat (10) @(posedge clk_sys);
        sense <= 18'h0;
        repeat (10) @(posedge clk_sys);
        chk(16'(int_n), 16'h0);
        rd(8'h95, 8'h10);
        rd(8'h95, 8'h00);
        chk(16'(int_n), 16'h1);
        wr(8'h14, 8'h02);
        @(posedge clk_sys) sense <= 18'h8;
        repeat (10) @(posedge clk_sys);
        rd(8'h95, 8'h00);
        wr(8'h3f, 8'h01);
        rd(8'h81, 8'h3f);
        chk(16'(act), 16'h0);
        test_done();
    end
    initial begin
        #100us;
        fails++;
        test_done();
    end
endmodule : tb
`default_nettype wire
